// ### hw/iast_pkg.sv
// Purpose: shared constants and carriers for the indirect access / sram test port
// Assumes: 16-bit registers reached by a byte register address from the serial decoder
// Notes: field layouts are carried by the packed structs below
package iast_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] IAST_TEST_CTL_OFS = 8'h1D;
    localparam logic [7:0] IAST_CTL_OFS = 8'h1E;
    localparam logic [7:0] IAST_DATA_OFS = 8'h1F;
    localparam logic [7:0] IAST_ALIAS_FIRST_OFS = 8'h20;
    localparam logic [7:0] IAST_ALIAS_LAST_OFS = 8'h2E;

    // values after reset
    localparam logic [15:0] IAST_CTL_RESET = 16'h0000;
    localparam logic [15:0] IAST_TEST_CTL_RESET = 16'h0000;
    localparam logic [15:0] IAST_DATA_RESET = 16'h0000;
    localparam logic [15:0] IAST_UNMAPPED_READ = 16'h0000;

    // sram geometry: 16 y/c rams plus the output buffer ram
    localparam int IAST_SRAM_COUNT = 17;
    localparam int IAST_SRAM_DEPTH = 800;
    localparam logic [4:0] IAST_OBUF_IDX = 5'h10;
    localparam logic [9:0] IAST_TEST_ADDR_LAST = 10'h31F;
    localparam int IAST_BURST_MAX = 16;

    // indirect access control register layout
    typedef struct packed {
        logic autoInc;
        logic wrEn;
        logic burstEn;
        logic [1:0] unused;
        logic [10:0] addr;
    } iast_ctl_t;

    // sram test control register layout
    typedef struct packed {
        logic wrEn;
        logic obufSel;
        logic bankLuma;
        logic [2:0] sramSel;
        logic [9:0] addr;
    } iast_tctl_t;

    // strobe group toward the indirect register space
    typedef struct packed {
        logic wr;
        logic rd;
        logic [10:0] addr;
        logic [15:0] wdata;
    } iast_ind_t;

endpackage

// ### hw/iast_indirect_access.sv
// What this block does
// R1 - output-buffer select set: test reads take data from the output buffer ram
// R2 - output-buffer select never affects test writes
// R3 - test write enable 1: data port access writes value into all seventeen srams
// R4 - test write enable 0: data port access reads selected sram into data register
// R5 - control register low 11 bits hold the indirect target address
// R6 - burst enable puts decoder in burst mode for data port, up to 16 transfers
// R7 - indirect write enable 1 writes target location, 0 reads it
// R8 - auto-increment advances indirect address by one after each data port access
// R9 - data port access acts on target like direct access; auto-increment forms bursts
// R10 - data port targets indirect registers, or test srams when sram test select is 1
// R11 - in burst mode addresses 0x20..0x2E behave exactly like the data port
// R12 - sram test address 0..799 advances after every test read or write
// R13 - bank bit picks luma (1) or chroma (0) group; 3-bit field picks ram
// R14 - control bits 12:11 read as zero and ignore writes
//
// Purpose: indirect register access port with test path to the encoder srams
// Assumes: one register access per cycle at most, at least two cycles apart
// Notes: indirect reads complete one cycle after the strobe
module iast_indirect_access
    import iast_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    input wire logic sramTestSelect,
    output logic burstMode,
    output iast_ind_t indPort,
    input wire logic [15:0] indRdData
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // data port or, in burst mode, one of its aliases
    function automatic logic isDataPort(input logic [7:0] addr, input logic burst);
        logic hit;
        hit = (addr == IAST_DATA_OFS);
        if (burst && addr >= IAST_ALIAS_FIRST_OFS && addr <= IAST_ALIAS_LAST_OFS)
        begin
            hit = 1'b1; // [R11]
        end
        return hit;
    endfunction

    iast_ctl_t ctl_reg, ctl_next;
    iast_tctl_t tctl_reg, tctl_next;
    logic [15:0] data_reg, data_next;
    logic [15:0] rdData_reg, rdData_next;
    iast_ind_t ind_reg, ind_next;
    logic pend_reg, pend_next;
    logic wrAcc, rdAcc, acc, tstAcc, tstWr, tstRd;
    logic [15:0] accData, rdWord;
    logic [4:0] rdIdx;
    logic [15:0] sramMem [IAST_SRAM_COUNT][IAST_SRAM_DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // access classification

    // write beats read if the decoder ever raises both
    always_comb
    begin
        wrAcc = regWrEn && isDataPort(regAddr, ctl_reg.burstEn); // [R9]
        rdAcc = regRdEn && !regWrEn && isDataPort(regAddr, ctl_reg.burstEn); // [R9]
        acc = wrAcc || rdAcc;
        accData = wrAcc ? regWrData : data_reg;
        tstAcc = acc && sramTestSelect; // [R10]
        tstWr = tstAcc && tctl_reg.wrEn; // [R3]
        tstRd = tstAcc && !tctl_reg.wrEn; // [R4]
        // obuf wins over the y/c bank choice, only on the read side
        rdIdx = tctl_reg.obufSel ? IAST_OBUF_IDX : {1'b0, tctl_reg.bankLuma, tctl_reg.sramSel}; // [R1] [R13]
        rdWord = sramMem[rdIdx][tctl_reg.addr];
    end

    ////////////////////////////////////////////////////////////////////////////
    // next register state

    always_comb
    begin
        ctl_next = ctl_reg;
        tctl_next = tctl_reg;
        data_next = data_reg;
        ind_next = '0;
        pend_next = 1'b0;
        rdData_next = rdData_reg;
        if (regWrEn && regAddr == IAST_CTL_OFS)
        begin
            ctl_next = iast_ctl_t'(regWrData); // [R5] [R6]
            ctl_next.unused = 2'b00; // [R14]
        end
        if (regWrEn && regAddr == IAST_TEST_CTL_OFS)
        begin
            tctl_next = iast_tctl_t'(regWrData);
        end
        // indirect read returns one cycle after its strobe
        if (pend_reg)
        begin
            data_next = indRdData; // [R7]
        end
        // a fresh host write overrides a late fill
        if (wrAcc)
        begin
            data_next = regWrData;
        end
        if (acc)
        begin
            if (ctl_reg.autoInc)
            begin
                ctl_next.addr = ctl_reg.addr + 11'h001; // [R8]
            end
            if (tstAcc)
            begin
                tctl_next.addr = (tctl_reg.addr >= IAST_TEST_ADDR_LAST) ? 10'h000 : tctl_reg.addr + 10'h001; // [R12]
                if (tstRd)
                begin
                    data_next = rdWord; // [R4]
                end
            end
            else
            begin
                ind_next.addr = ctl_reg.addr; // [R5]
                ind_next.wdata = accData;
                ind_next.wr = ctl_reg.wrEn; // [R7]
                ind_next.rd = !ctl_reg.wrEn; // [R7]
                pend_next = !ctl_reg.wrEn;
            end
        end
        // read data shows the register before this access acts on it
        if (regRdEn)
        begin
            if (regAddr == IAST_CTL_OFS)
            begin
                rdData_next = ctl_reg; // [R14]
            end
            else if (regAddr == IAST_TEST_CTL_OFS)
            begin
                rdData_next = tctl_reg;
            end
            else if (isDataPort(regAddr, ctl_reg.burstEn))
            begin
                rdData_next = data_reg; // [R11]
            end
            else
            begin
                rdData_next = IAST_UNMAPPED_READ;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctl_reg <= iast_ctl_t'(IAST_CTL_RESET);
            tctl_reg <= iast_tctl_t'(IAST_TEST_CTL_RESET);
            data_reg <= IAST_DATA_RESET;
            rdData_reg <= IAST_UNMAPPED_READ;
            ind_reg <= '0;
            pend_reg <= 1'b0;
        end
        else
        begin
            ctl_reg <= ctl_next;
            tctl_reg <= tctl_next;
            data_reg <= data_next;
            rdData_reg <= rdData_next;
            ind_reg <= ind_next;
            pend_reg <= pend_next;
        end
    end

    // test write lands in every ram at once; obuf select plays no part
    always_ff @(posedge clk)
    begin
        if (tstWr)
        begin
            for (int i = 0; i < IAST_SRAM_COUNT; i++)
            begin
                sramMem[i][tctl_reg.addr] <= accData; // [R3] [R2]
            end
        end
    end

    assign regRdData = rdData_reg;
    assign indPort = ind_reg;
    assign burstMode = ctl_reg.burstEn; // [R6]

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_obuf_read;
        tstRd && tctl_reg.obufSel |=> data_reg == sramMem[IAST_OBUF_IDX][$past(tctl_reg.addr)];
    endproperty
    a_obuf_read: assert property (p_obuf_read) else $error("obuf read took wrong ram"); // [R1]

    property p_write_all;
        wrAcc && sramTestSelect && tctl_reg.wrEn |=> sramMem[0][$past(tctl_reg.addr)] == $past(regWrData)
            && sramMem[16][$past(tctl_reg.addr)] == $past(regWrData);
    endproperty
    a_write_all: assert property (p_write_all) else $error("test write missed a ram"); // [R3]

    // obuf select must not keep the broadcast from reaching the y/c rams
    property p_write_ignores_obuf;
        tstAcc && tctl_reg.wrEn && tctl_reg.obufSel |=> data_reg == $past(accData)
            && sramMem[0][$past(tctl_reg.addr)] == $past(accData);
    endproperty
    a_write_ignores_obuf: assert property (p_write_ignores_obuf) else $error("obuf changed a write"); // [R2]

    // expected ram worked out from the field layout, not from the read mux
    property p_test_read;
        tstRd |=> data_reg == ($past(tctl_reg.obufSel) ? sramMem[IAST_OBUF_IDX][$past(tctl_reg.addr)]
            : sramMem[{$past(tctl_reg.bankLuma), $past(tctl_reg.sramSel)}][$past(tctl_reg.addr)]);
    endproperty
    a_test_read: assert property (p_test_read) else $error("test read not loaded"); // [R4]

    property p_unused_zero;
        regRdEn && regAddr == IAST_CTL_OFS |=> regRdData[12:11] == 2'b00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero"); // [R14]

    property p_ind_write;
        acc && !sramTestSelect && ctl_reg.wrEn |=> indPort.wr && !indPort.rd && indPort.addr == $past(ctl_reg.addr);
    endproperty
    a_ind_write: assert property (p_ind_write) else $error("indirect write strobe wrong"); // [R7]

    property p_ind_read;
        acc && !sramTestSelect && !ctl_reg.wrEn |=> indPort.rd ##1 (data_reg == $past(indRdData) || $past(wrAcc));
    endproperty
    a_ind_read: assert property (p_ind_read) else $error("indirect read not returned"); // [R7]

    property p_auto_inc;
        acc && ctl_reg.autoInc |=> ctl_reg.addr == $past(ctl_reg.addr) + 11'h001;
    endproperty
    a_auto_inc: assert property (p_auto_inc) else $error("address did not advance"); // [R8]

    property p_test_addr_wrap;
        tstAcc && tctl_reg.addr == IAST_TEST_ADDR_LAST |=> tctl_reg.addr == 10'h000;
    endproperty
    a_test_addr_wrap: assert property (p_test_addr_wrap) else $error("test address wrap wrong"); // [R12]

    property p_alias;
        regWrEn && ctl_reg.burstEn && !sramTestSelect && regAddr >= IAST_ALIAS_FIRST_OFS
            && regAddr <= IAST_ALIAS_LAST_OFS |=> (indPort.wr || indPort.rd) && data_reg == $past(regWrData);
    endproperty
    a_alias: assert property (p_alias) else $error("alias not a data port"); // [R11]

    c_burst_alias: cover property (wrAcc && regAddr == IAST_ALIAS_LAST_OFS);
    c_obuf_read: cover property (tstRd && tctl_reg.obufSel);
    c_ind_read_back: cover property (indPort.rd && pend_reg);
    c_addr_wrap: cover property (tstAcc && tctl_reg.addr == IAST_TEST_ADDR_LAST);

endmodule

// ### tb/iast_ind_space_model.sv
// Purpose: behavioural indirect register space behind the indirect port
// Assumes: strobes are one-cycle pulses, read data sampled in or just after the read cycle
// Notes: read data goes to the inverse of the last value once its window has passed
module iast_ind_space_model
    import iast_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire iast_ind_t ind,
    output logic [15:0] rdData,
    output logic [15:0] wrCount
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] mem [2048];
    logic [15:0] holdReg;
    logic holdValid;

    ////////////////////////////////////////////////////////////////////////////
    // storage and strobe bookkeeping; contents cleared on reset so unwritten reads are known
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wrCount <= 16'h0000;
            holdValid <= 1'b0;
            holdReg <= 16'h0000;
            for (int i = 0; i < 2048; i++)
            begin
                mem[i] <= 16'h0000;
            end
        end
        else
        begin
            if (ind.wr)
            begin
                mem[ind.addr] <= ind.wdata;
                wrCount <= wrCount + 16'h0001;
            end
            holdValid <= ind.rd;
            if (ind.rd)
                holdReg <= mem[ind.addr];
        end
    end

    // data valid during the read cycle and one after, garbage otherwise
    assign rdData = ind.rd ? mem[ind.addr] : (holdValid ? holdReg : ~holdReg);
endmodule

// ### tb/test_indirect_access_sram_test.sv
// Purpose: self-checking bench for the indirect access and sram test port
// Assumes: accesses spaced four cycles apart, data port reads are prefetch style
// Notes: random data from a fixed seed, wrap corners chosen by hand
module test_indirect_access_sram_test
    import iast_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk;
    logic srst;
    logic regWrEn;
    logic regRdEn;
    logic [7:0] regAddr;
    logic [15:0] regWrData;
    logic [15:0] regRdData;
    logic sramTestSelect;
    logic burstMode;
    iast_ind_t indPort;
    logic [15:0] indRdData;
    logic [15:0] wrCount;
    int errCount = 0;
    int checksDone = 0;

    iast_indirect_access uut (.clk(clk), .srst(srst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .sramTestSelect(sramTestSelect), .burstMode(burstMode), .indPort(indPort), .indRdData(indRdData));
    iast_ind_space_model model (.clk(clk), .srst(srst), .ind(indPort), .rdData(indRdData), .wrCount(wrCount));

    ////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic printVerdict;
        if (errCount == 0 && checksDone > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            errCount++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one write strobe, then idle so an indirect fill lands first
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        @(negedge clk);
        v = regRdData;
        repeat (2) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        #500000;
        errCount++;
        printVerdict;
    end

    initial
    begin
        logic [15:0] v;
        logic [15:0] t;
        logic [15:0] c0;
        logic [15:0] wd [4];
        logic [7:0] a;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 16'h0000;
        sramTestSelect = 1'b0;
        srst = 1'b1;
        void'($urandom(32'hd738));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        // reset values
        rd(IAST_CTL_OFS, v);
        chk("ctl reset", v, IAST_CTL_RESET);
        rd(IAST_TEST_CTL_OFS, v);
        chk("test ctl reset", v, IAST_TEST_CTL_RESET);
        rd(IAST_DATA_OFS, v);
        chk("data reset", v, IAST_DATA_RESET);
        // unused bits dropped, address kept
        wr(IAST_CTL_OFS, 16'h1ABC);
        rd(IAST_CTL_OFS, v);
        chk("ctl unused", v, 16'h02BC);
        chk("burst off", {15'h0000, burstMode}, 16'h0000);
        // alias refused outside burst mode
        c0 = wrCount;
        wr(8'h25, 16'h5A5A);
        rd(8'h25, v);
        chk("alias idle", v, IAST_UNMAPPED_READ);
        chk("alias no strobe", wrCount, c0);
        // burst writes through data port and aliases, address wraps at 11 bits
        wr(IAST_CTL_OFS, 16'hE7FE);
        chk("burst on", {15'h0000, burstMode}, 16'h0001);
        for (int i = 0; i < 4; i++)
        begin
            wd[i] = 16'($urandom);
            a = (i == 0) ? IAST_DATA_OFS : (i == 3) ? IAST_ALIAS_LAST_OFS : 8'(IAST_ALIAS_FIRST_OFS + i);
            wr(a, wd[i]);
        end
        chk("ind writes", wrCount, 16'(c0 + 16'h0004));
        rd(IAST_CTL_OFS, v);
        chk("ctl advanced", v, 16'hE002);
        // read back with auto-increment, first read is the stale prefetch
        wr(IAST_CTL_OFS, 16'h87FE);
        rd(IAST_DATA_OFS, v);
        for (int i = 0; i < 4; i++)
        begin
            rd(IAST_DATA_OFS, v);
            chk("ind read", v, wd[i]);
        end
        // sram test writes with output buffer select set, across the 799 wrap
        sramTestSelect <= 1'b1;
        c0 = wrCount;
        wr(IAST_TEST_CTL_OFS, 16'hC31E);
        for (int i = 0; i < 3; i++)
        begin
            wd[i] = 16'($urandom);
            wr(IAST_DATA_OFS, wd[i]);
        end
        rd(IAST_TEST_CTL_OFS, v);
        chk("test addr wrap", v, 16'hC001);
        // every ram group and the output buffer hold the broadcast words
        for (int k = 0; k < 4; k++)
        begin
            t = 16'h031E | (k >= 2 ? 16'h4000 : 16'h0000) | (k[0] ? 16'h2000 : 16'h0000);
            t[12:10] = 3'($urandom_range(7));
            wr(IAST_TEST_CTL_OFS, t);
            rd(IAST_DATA_OFS, v);
            for (int i = 0; i < 3; i++)
            begin
                rd(IAST_DATA_OFS, v);
                chk("sram read", v, wd[i]);
            end
        end
        chk("no ind strobe", wrCount, c0);
        printVerdict;
    end
endmodule
